// *** hw/bfs_pct_div.sv ***
// Small restoring divider giving elapsed delay as a percentage below 100
`timescale 1ns/1ps
module bfs_pct_div #(
	parameter int unsigned W = 20
) (
	input  wire logic         core_clk_in,  // Core clock
	input  wire logic         sys_rst_in,   // Async reset, high
	input  wire logic         go_in,        // Start pulse
	input  wire logic [W+6:0] num_in,       // Elapsed ms times 100
	input  wire logic [W-1:0] den_in,       // Operate delay in ms
	output logic              done_out,     // Result valid pulse
	output logic [7:0]        pct_out       // Quotient
);
	logic [W+6:0] rem_q;
	logic [W+6:0] den_q;
	logic [2:0]   idx_q;
	logic         busy_q;
	logic [W+6:0] trial;
	logic         fits;

	// Numerator is below 100 times the divisor, so seven quotient bits suffice
	assign trial = den_q << idx_q;
	assign fits  = rem_q >= trial;

	// One quotient bit per cycle, most significant first
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rem_q    <= '0;
			den_q    <= '0;
			idx_q    <= 3'h0;
			busy_q   <= 1'b0;
			done_out <= 1'b0;
			pct_out  <= 8'h00;
		end else begin
			done_out <= 1'b0;
			if (go_in) begin
				rem_q   <= num_in;
				den_q   <= {7'h00, den_in};
				idx_q   <= 3'(bfs_pkg::PCT_BITS - 1);
				busy_q  <= 1'b1;
				pct_out <= 8'h00;
			end else if (busy_q) begin
				if (fits) begin
					rem_q          <= rem_q - trial;
					pct_out[idx_q] <= 1'b1;
				end
				if (idx_q == 3'h0) begin
					busy_q   <= 1'b0;
					done_out <= 1'b1;
				end else begin
					idx_q <= idx_q - 3'h1;
				end
			end
		end
	end
endmodule : bfs_pct_div

// *** hw/bfs_stage.sv ***
// Breaker failure supervision stage with backup trip and fault records
// What this block does
// (R1) It watches the control signal of the chosen primary trip relay and times how long it stays active.
// (R2) When that signal outlasts the operate delay, the stage trips and energises the backup relay.
// (R3) The backup relay stays on until the supervised primary relay signal returns to reset.
// (R4) Software must route the backup trip to a contact other than the supervised relay.
// (R5) Any protection stage mapped onto the supervised relay starts the supervision.
// (R6) The selection value 1 picks relay one and value 2 picks relay two.
// (R7) Status reads blocked, started or tripped, and start or trip can be written only while forcing.
// (R8) Start and trip counters accumulate and each clears on an explicit write, to one if its state rises in that cycle.
// (R9) One shared force flag allows status forcing and drops by itself after five minutes.
// (R10) Editable settings accept writes only after the password has been given.
// (R11) The eight latest faults are kept, each with time stamp and elapsed delay, oldest lost first.
// (R12) Each time stamp holds year, month, day and time of day to the millisecond.
// (R13) Elapsed delay is stored as percent of the operate delay, 100 meaning a trip.
// (R14) Each counter steps once on the rising edge of its state.
// (R15) Timing starts when the watched signal asserts and restarts from zero if it drops early.
`timescale 1ns/1ps
module bfs_stage #(
	parameter int unsigned         DLY_W      = 20,
	parameter int unsigned         CYC_PER_MS = bfs_pkg::CYC_PER_MS,
	parameter int unsigned         FORCE_MS   = bfs_pkg::FORCE_TMO_MS,
	parameter logic [31:0]         PASS_KEY   = 32'h0000a5c3 // Arbitrary value
) (
	input  wire logic                 core_clk_in,         // Core clock
	input  wire logic                 sys_rst_in,          // Async reset, high
	input  wire bfs_pkg::bfs_req_t    bus_in,              // Register request
	output logic [31:0]               rd_data_out,         // Read data, one cycle later
	input  wire logic                 trip_relay_one_in,   // Control of first trip relay
	input  wire logic                 trip_relay_two_in,   // Control of second trip relay
	input  wire logic                 block_in,            // Stage block
	input  wire bfs_pkg::bfs_stamp_t  stamp_in,            // Relay timebase
	output logic                      backup_relay_out,    // Backup trip relay drive
	output logic                      start_out,           // Stage started
	output logic                      trip_out,            // Stage tripped
	output logic                      force_out            // Shared force flag
);
	// ************************************
	// Parameter checks
	// ************************************
	if (DLY_W < 10 || DLY_W > 24 || CYC_PER_MS < 2 || FORCE_MS < 1) begin : g_bad
		$error("bfs_stage: unsupported parameter values");
	end

	localparam int unsigned PRE_W = $clog2(CYC_PER_MS);
	localparam int unsigned FRC_W = $clog2(FORCE_MS + 1);

	// ************************************
	// Declarations
	// ************************************
	bfs_pkg::bfs_state_t  st_q, st_d;
	bfs_pkg::bfs_state_t  frc_st_q;
	bfs_pkg::bfs_state_t  eff_st;
	bfs_pkg::bfs_rec_t    rec_mem [bfs_pkg::REC_DEPTH];
	bfs_pkg::bfs_rec_t    rd_rec;
	bfs_pkg::bfs_stamp_t  hold_stamp_q;
	logic [1:0]           sel_q;
	logic [DLY_W-1:0]     delay_q;
	logic [DLY_W-1:0]     elapsed_q;
	logic [PRE_W-1:0]     pre_q;
	logic [FRC_W-1:0]     frc_cnt_q;
	logic                 ms_tick;
	logic                 unlocked_q;
	logic                 frc_valid_q;
	logic [31:0]          start_event_count_q;
	logic [31:0]          trip_event_count_q;
	logic                 was_start_q;
	logic                 was_trip_q;
	logic [2:0]           wr_ptr_q;
	logic [3:0]           rec_cnt_q;
	logic [2:0]           rec_idx_q;
	logic [2:0]           rd_slot;
	logic                 supervised;
	logic                 expired;
	logic                 early_drop;
	logic                 to_trip;
	logic                 div_done;
	logic [7:0]           div_pct;
	logic [31:0]          rd_mux;
	logic                 wr_sel, wr_delay, wr_key, wr_status, wr_force;
	logic                 wr_scnt, wr_tcnt, wr_idx;
	logic                 start_rise, trip_rise;
	logic                 rec_wr;
	logic [7:0]           rec_pct;

	// Address match for one register on one strobe
	function automatic logic hit(input logic stb, input logic [7:0] a, input logic [7:0] off);
		hit = stb && (a == off);
	endfunction : hit

	// ************************************
	// Register decode
	// ************************************
	// Settings and the force flag need the password; status writes need the force flag, counters have no gate
	assign wr_sel    = hit(bus_in.wr, bus_in.addr, bfs_pkg::OFF_SEL) && unlocked_q;       // [R10]
	assign wr_delay  = hit(bus_in.wr, bus_in.addr, bfs_pkg::OFF_DELAY) && unlocked_q;     // [R10]
	assign wr_force  = hit(bus_in.wr, bus_in.addr, bfs_pkg::OFF_FORCE) && unlocked_q;     // [R10]
	assign wr_key    = hit(bus_in.wr, bus_in.addr, bfs_pkg::OFF_KEY);
	assign wr_status = hit(bus_in.wr, bus_in.addr, bfs_pkg::OFF_STATUS) && force_out;     // [R7]
	assign wr_scnt   = hit(bus_in.wr, bus_in.addr, bfs_pkg::OFF_SCNT);
	assign wr_tcnt   = hit(bus_in.wr, bus_in.addr, bfs_pkg::OFF_TCNT);
	assign wr_idx    = hit(bus_in.wr, bus_in.addr, bfs_pkg::OFF_REC_IDX);

	// ************************************
	// Supervision
	// ************************************
	// Watching the relay drive itself catches every stage mapped onto it
	assign supervised = (sel_q == bfs_pkg::SEL_TWO) ? trip_relay_two_in : trip_relay_one_in; // [R1] [R5] [R6]
	assign ms_tick    = (pre_q == PRE_W'(CYC_PER_MS - 1));
	assign expired    = (elapsed_q >= delay_q);
	assign early_drop = (st_q == bfs_pkg::ST_START) && !supervised;
	assign to_trip    = (st_q == bfs_pkg::ST_START) && supervised && !block_in && expired;

	// Next state of the live supervision
	always_comb begin
		st_d = st_q;
		case (st_q)
			bfs_pkg::ST_IDLE: begin
				if (block_in)
					st_d = bfs_pkg::ST_BLOCK;
				else if (supervised)
					st_d = bfs_pkg::ST_START;                       // [R15]
			end
			bfs_pkg::ST_BLOCK: begin
				if (!block_in)
					st_d = bfs_pkg::ST_IDLE;
			end
			bfs_pkg::ST_START: begin
				if (!supervised)
					st_d = bfs_pkg::ST_IDLE;                        // [R15]
				else if (block_in)
					st_d = bfs_pkg::ST_BLOCK;
				else if (expired)
					st_d = bfs_pkg::ST_TRIP;                        // [R2]
			end
			bfs_pkg::ST_TRIP: begin
				if (!supervised)
					st_d = bfs_pkg::ST_IDLE;                        // [R3]
			end
			default: st_d = bfs_pkg::ST_IDLE;
		endcase
	end

	// A forced status overrides the live one while forcing lasts
	assign eff_st     = (force_out && frc_valid_q) ? frc_st_q : st_d;  // [R7]
	assign start_rise = (eff_st == bfs_pkg::ST_START) && !was_start_q;
	assign trip_rise  = (eff_st == bfs_pkg::ST_TRIP) && !was_trip_q;

	// Millisecond prescaler and delay timer
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pre_q     <= '0;
			elapsed_q <= '0;
			st_q      <= bfs_pkg::ST_IDLE;
		end else begin
			pre_q <= ms_tick ? '0 : pre_q + PRE_W'(1);
			st_q  <= st_d;
			if (st_d != bfs_pkg::ST_START || st_q != bfs_pkg::ST_START)
				elapsed_q <= '0;                                    // [R15]
			else if (ms_tick && !expired)
				elapsed_q <= elapsed_q + DLY_W'(1);                 // [R1]
		end
	end

	// ************************************
	// Settings, password and force flag
	// ************************************
	// The force flag times out so a forgotten test cannot leave outputs forced
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			sel_q       <= bfs_pkg::SEL_RST;
			delay_q     <= DLY_W'(bfs_pkg::DELAY_RST);
			unlocked_q  <= 1'b0;
			force_out   <= 1'b0;
			frc_cnt_q   <= '0;
			frc_valid_q <= 1'b0;
			frc_st_q    <= bfs_pkg::ST_IDLE;
		end else begin
			if (wr_key)
				unlocked_q <= (bus_in.wdata == PASS_KEY);           // [R10]
			if (wr_sel && (bus_in.wdata[1:0] == bfs_pkg::SEL_ONE || bus_in.wdata[1:0] == bfs_pkg::SEL_TWO))
				sel_q <= bus_in.wdata[1:0];                         // [R6]
			if (wr_delay && bus_in.wdata[DLY_W-1:0] != '0)
				delay_q <= bus_in.wdata[DLY_W-1:0];
			if (wr_force) begin
				force_out <= bus_in.wdata[0];                       // [R9]
				frc_cnt_q <= '0;
			end else if (force_out && ms_tick) begin
				if (frc_cnt_q == FRC_W'(FORCE_MS - 1))
					force_out <= 1'b0;                              // [R9]
				frc_cnt_q <= frc_cnt_q + FRC_W'(1);
			end
			if (!force_out)
				frc_valid_q <= 1'b0;
			else if (wr_status) begin
				frc_st_q    <= bfs_pkg::bfs_state_t'(bus_in.wdata[1:0]);
				frc_valid_q <= bus_in.wdata[1];                     // [R7]
			end
		end
	end

	// ************************************
	// Counters and outputs
	// ************************************
	// A rising edge in the clearing cycle still counts, so no event is lost
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			start_event_count_q <= '0;
			trip_event_count_q  <= '0;
			was_start_q         <= 1'b0;
			was_trip_q          <= 1'b0;
			start_out           <= 1'b0;
			trip_out            <= 1'b0;
			backup_relay_out    <= 1'b0;
		end else begin
			was_start_q <= (eff_st == bfs_pkg::ST_START);
			was_trip_q  <= (eff_st == bfs_pkg::ST_TRIP);
			if (wr_scnt)
				start_event_count_q <= {31'h0, start_rise};         // [R8]
			else if (start_rise)
				start_event_count_q <= start_event_count_q + 32'h1; // [R14]
			if (wr_tcnt)
				trip_event_count_q <= {31'h0, trip_rise};           // [R8]
			else if (trip_rise)
				trip_event_count_q <= trip_event_count_q + 32'h1;   // [R14]
			start_out        <= (eff_st == bfs_pkg::ST_START);
			trip_out         <= (eff_st == bfs_pkg::ST_TRIP);
			backup_relay_out <= (eff_st == bfs_pkg::ST_TRIP);       // [R2] [R3]
		end
	end

	// ************************************
	// Fault records
	// ************************************
	// An early drop needs a division; a trip is 100 percent at once
	bfs_pct_div #(
		.W (DLY_W)
	) u_div (
		.core_clk_in (core_clk_in),
		.sys_rst_in  (sys_rst_in),
		.go_in       (early_drop),
		.num_in      ((DLY_W+7)'(elapsed_q) * (DLY_W+7)'(100)),     // [R13]
		.den_in      (delay_q),
		.done_out    (div_done),
		.pct_out     (div_pct)
	);

	assign rec_wr  = to_trip || div_done;                           // [R11]
	assign rec_pct = to_trip ? bfs_pkg::PCT_FULL : div_pct;         // [R13]

	// Stamp is caught when the episode ends; the ring drops the oldest entry
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			hold_stamp_q <= '0;
			wr_ptr_q     <= 3'h0;
			rec_cnt_q    <= 4'h0;
			rec_idx_q    <= 3'h0;
		end else begin
			if (early_drop)
				hold_stamp_q <= stamp_in;                           // [R12]
			if (wr_idx)
				rec_idx_q <= bus_in.wdata[2:0];
			if (rec_wr) begin
				wr_ptr_q <= wr_ptr_q + 3'h1;                        // [R11]
				if (rec_cnt_q != 4'(bfs_pkg::REC_DEPTH))
					rec_cnt_q <= rec_cnt_q + 4'h1;
			end
		end
	end

	// Record storage has no reset; the count tells which entries are valid
	always_ff @(posedge core_clk_in) begin
		if (rec_wr) begin
			rec_mem[wr_ptr_q].stamp <= to_trip ? stamp_in : hold_stamp_q; // [R12]
			rec_mem[wr_ptr_q].pct   <= rec_pct;
		end
	end

	// ************************************
	// Read path
	// ************************************
	// Index 0 is the newest record
	assign rd_slot = wr_ptr_q - 3'h1 - rec_idx_q;
	assign rd_rec  = rec_mem[rd_slot];

	always_comb begin
		case (bus_in.addr)
			bfs_pkg::OFF_SEL:     rd_mux = {30'h0, sel_q};
			bfs_pkg::OFF_DELAY:   rd_mux = 32'(delay_q);
			bfs_pkg::OFF_KEY:     rd_mux = {31'h0, unlocked_q};
			bfs_pkg::OFF_STATUS:  rd_mux = {30'h0, eff_st};             // [R7]
			bfs_pkg::OFF_FORCE:   rd_mux = {31'h0, force_out};
			bfs_pkg::OFF_SCNT:    rd_mux = start_event_count_q;
			bfs_pkg::OFF_TCNT:    rd_mux = trip_event_count_q;
			bfs_pkg::OFF_REC_IDX: rd_mux = {29'h0, rec_idx_q};
			bfs_pkg::OFF_REC_DAT: rd_mux = {rd_rec.stamp.year, rd_rec.stamp.month, rd_rec.stamp.day};
			bfs_pkg::OFF_REC_TOD: rd_mux = {5'h0, rd_rec.stamp.hour, rd_rec.stamp.minute,
			                                rd_rec.stamp.second, rd_rec.stamp.msec};
			bfs_pkg::OFF_REC_PCT: rd_mux = {24'h0, rd_rec.pct};
			bfs_pkg::OFF_REC_CNT: rd_mux = {28'h0, rec_cnt_q};
			default:              rd_mux = 32'h0;
		endcase
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			rd_data_out <= 32'h0;
		else
			rd_data_out <= bus_in.rd ? rd_mux : 32'h0;
	end
endmodule : bfs_stage

// *** shared/bfs_pkg.sv ***
// Constants, types and register map of the breaker failure stage
package bfs_pkg;

	// ************************************
	// Timing
	// ************************************
	localparam int unsigned CLK_HZ         = 125_000_000;
	localparam int unsigned MS_PER_S       = 1000;
	localparam int unsigned CYC_PER_MS     = CLK_HZ / MS_PER_S;
	localparam int unsigned FORCE_TMO_MIN  = 5;
	localparam int unsigned FORCE_TMO_MS   = FORCE_TMO_MIN * 60 * MS_PER_S;

	// ************************************
	// Register offsets
	// ************************************
	localparam int unsigned ADDR_W      = 8;
	localparam logic [7:0]  OFF_SEL     = 8'h00;
	localparam logic [7:0]  OFF_DELAY   = 8'h04;
	localparam logic [7:0]  OFF_KEY     = 8'h08;
	localparam logic [7:0]  OFF_STATUS  = 8'h0c;
	localparam logic [7:0]  OFF_FORCE   = 8'h10;
	localparam logic [7:0]  OFF_SCNT    = 8'h14;
	localparam logic [7:0]  OFF_TCNT    = 8'h18;
	localparam logic [7:0]  OFF_REC_IDX = 8'h1c;
	localparam logic [7:0]  OFF_REC_DAT = 8'h20;
	localparam logic [7:0]  OFF_REC_TOD = 8'h24;
	localparam logic [7:0]  OFF_REC_PCT = 8'h28;
	localparam logic [7:0]  OFF_REC_CNT = 8'h2c;

	// ************************************
	// Field values and reset values
	// ************************************
	localparam logic [1:0]  SEL_ONE     = 2'h1;
	localparam logic [1:0]  SEL_TWO     = 2'h2;
	localparam logic [1:0]  SEL_RST     = 2'h1;
	localparam logic [19:0] DELAY_RST   = 20'h00032;
	localparam logic [7:0]  PCT_FULL    = 8'h64;
	localparam int unsigned PCT_BITS    = 7;
	localparam int unsigned REC_DEPTH   = 8;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_BLOCK = 2'b01,
		ST_START = 2'b10,
		ST_TRIP  = 2'b11
	} bfs_state_t;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} bfs_req_t;

	typedef struct packed {
		logic [15:0] year;
		logic [7:0]  month;
		logic [7:0]  day;
		logic [4:0]  hour;
		logic [5:0]  minute;
		logic [5:0]  second;
		logic [9:0]  msec;
	} bfs_stamp_t;

	typedef struct packed {
		bfs_stamp_t  stamp;
		logic [7:0]  pct;
	} bfs_rec_t;

endpackage : bfs_pkg

// *** tb/bfs_relay_model.sv ***
// Behavioural model of the trip relays and the upstream breaker
`timescale 1ns/1ps
module bfs_relay_model (
	input  wire logic core_clk_in,      // Core clock
	input  wire logic sys_rst_in,       // Async reset, high
	input  wire logic stage_a_in,       // First stage mapped on relay one
	input  wire logic stage_b_in,       // Second stage mapped on relay one
	input  wire logic stage_c_in,       // Stage mapped on relay two
	input  wire logic backup_in,        // Backup trip drive
	output logic      relay_one_out,    // Relay one control
	output logic      relay_two_out,    // Relay two control
	output logic      upstream_open_out // Upstream breaker opened
);
	// Output matrix: stages share relay one, either one starts supervision
	assign relay_one_out = stage_a_in | stage_b_in;
	assign relay_two_out = stage_c_in;
	// Backup has its own contact, never one of the supervised relays
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			upstream_open_out <= 1'b0;
		else
			upstream_open_out <= backup_in;
	end
endmodule : bfs_relay_model

// *** tb/bfs_stage_checker.sv ***
// Port checker of the breaker failure stage, bound to the design
`timescale 1ns/1ps
module bfs_stage_checker #(
	parameter int unsigned CYC_PER_MS = 4,
	parameter int unsigned FORCE_MS   = 20
) (
	input wire logic                core_clk_in,       // Core clock
	input wire logic                sys_rst_in,        // Async reset, high
	input wire bfs_pkg::bfs_req_t   bus_in,            // Register request
	input wire logic [31:0]         rd_data_out,       // Read data
	input wire logic                trip_relay_one_in, // Relay one control
	input wire logic                trip_relay_two_in, // Relay two control
	input wire logic                block_in,          // Stage block
	input wire bfs_pkg::bfs_stamp_t stamp_in,          // Timebase
	input wire logic                backup_relay_out,  // Backup relay
	input wire logic                start_out,         // Started
	input wire logic                trip_out,          // Tripped
	input wire logic                force_out          // Force flag
);
	// ********
	// Helper logic
	// ********
	logic [31:0] force_cnt_q; // Length of the running force period
	// A stuck force timer only shows as an overlong period
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			force_cnt_q <= 32'h0;
		else
			force_cnt_q <= force_out ? force_cnt_q + 32'h1 : 32'h0;
	end
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);
	// Three quiet samples cover the one-cycle release latency
	sequence relays_quiet;
		(!trip_relay_one_in && !trip_relay_two_in && !force_out)[*3];
	endsequence
	sequence relays_held;
		(trip_relay_one_in && trip_relay_two_in && !force_out)[*3];
	endsequence
	// ********
	// Assertions
	// ********
	rd_idle_zero_a: assert property (!$past(bus_in.rd) |-> rd_data_out == 32'h0)
		else $error("read data not zero outside a read answer");
	quiet_outputs_low_a: assert property (relays_quiet |-> !start_out && !trip_out && !backup_relay_out)
		else $error("stage active with both relays reset");
	backup_held_a: assert property (relays_held ##0 backup_relay_out |=> backup_relay_out)
		else $error("backup dropped while relay still energised");
	backup_drop_cause_a: assert property ($fell(backup_relay_out) && !force_out && !$past(force_out) &&
		!$past(force_out, 2) |-> $past(!trip_relay_one_in || !trip_relay_two_in))
		else $error("backup released while both relays energised");
	trip_after_start_a: assert property ($rose(trip_out) && !force_out |-> $past(start_out))
		else $error("trip without a preceding start");
	start_has_cause_a: assert property ($rose(start_out) |-> $past(trip_relay_one_in || trip_relay_two_in || force_out))
		else $error("start without relay signal");
	block_stops_start_a: assert property ((block_in && !trip_out && !force_out)[*3] |-> !start_out)
		else $error("start while blocked");
	force_by_write_a: assert property ($rose(force_out) |->
		$past(bus_in.wr && bus_in.addr == bfs_pkg::OFF_FORCE && bus_in.wdata[0]))
		else $error("force flag set without a write");
	force_timeout_a: assert property (force_cnt_q <= FORCE_MS * CYC_PER_MS + 2 * CYC_PER_MS)
		else $error("force flag outlived its timeout");
endmodule : bfs_stage_checker

bind bfs_stage bfs_stage_checker #(.CYC_PER_MS(CYC_PER_MS), .FORCE_MS(FORCE_MS)) i_bfs_stage_checker (
	.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .bus_in(bus_in), .rd_data_out(rd_data_out),
	.trip_relay_one_in(trip_relay_one_in), .trip_relay_two_in(trip_relay_two_in), .block_in(block_in),
	.stamp_in(stamp_in), .backup_relay_out(backup_relay_out), .start_out(start_out), .trip_out(trip_out),
	.force_out(force_out));

// *** tb/bfs_stage_tb.sv ***
// Self-checking bench of the breaker failure stage
`timescale 1ns/1ps
module bfs_stage_tb;
	localparam int unsigned CPM = 4;              // Shortened ms prescale
	localparam int unsigned FMS = 20;             // Shortened force timeout
	localparam logic [31:0] KEY = 32'h0000beef;   // Arbitrary value
	typedef struct packed {logic [7:0] a; logic [31:0] v; logic [31:0] e;} bfs_row_t;
	logic                core_clk_in, sys_rst_in, block_in, stg_a, stg_b, stg_c;
	logic                r1, r2, bkp, st, tr, frc, up_open;
	bfs_pkg::bfs_req_t   req;
	bfs_pkg::bfs_stamp_t stamp;
	logic [31:0]         rdat, d;
	int                  mismatches, tests_run, n;
	// Write, then read back: locked, key, selection, delay, status, unmapped
	bfs_row_t rows [10] = '{
		'{bfs_pkg::OFF_SEL, 32'h2, 32'h1}, '{bfs_pkg::OFF_KEY, 32'h1234, 32'h0},
		'{bfs_pkg::OFF_KEY, KEY, 32'h1}, '{bfs_pkg::OFF_SEL, 32'h3, 32'h1},
		'{bfs_pkg::OFF_SEL, 32'h2, 32'h2}, '{bfs_pkg::OFF_SEL, 32'h1, 32'h1},
		'{bfs_pkg::OFF_DELAY, 32'h0, 32'h32}, '{bfs_pkg::OFF_DELAY, 32'h2, 32'h2},
		'{bfs_pkg::OFF_STATUS, 32'h3, 32'h0}, '{8'h30, 32'h5, 32'h0}};

	bfs_stage #(.CYC_PER_MS(CPM), .FORCE_MS(FMS), .PASS_KEY(KEY)) i_bfs_stage (
		.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .bus_in(req), .rd_data_out(rdat),
		.trip_relay_one_in(r1), .trip_relay_two_in(r2), .block_in(block_in), .stamp_in(stamp),
		.backup_relay_out(bkp), .start_out(st), .trip_out(tr), .force_out(frc));
	bfs_relay_model i_bfs_relay_model (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
		.stage_a_in(stg_a), .stage_b_in(stg_b), .stage_c_in(stg_c), .backup_in(bkp),
		.relay_one_out(r1), .relay_two_out(r2), .upstream_open_out(up_open));

	// ********
	// Clock, watchdog and tasks
	// ********
	initial begin
		core_clk_in = 1'b0;
		forever #4 core_clk_in = ~core_clk_in;
	end
	// Whole run needs about 550 cycles
	initial begin
		repeat (20000) @(posedge core_clk_in);
		mismatches++;
		summarize();
	end
	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : summarize
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// Ends just after an edge so outputs have settled
	task automatic cyc(input int k);
		repeat (k) @(posedge core_clk_in);
		#1;
	endtask : cyc
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge core_clk_in);
		req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk_in);
		req <= '0;
	endtask : wr
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge core_clk_in);
		req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk_in);
		req <= '0;
		#1 v = rdat;
	endtask : rd
	task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] v;
		rd(a, v);
		check(what, v, e);
	endtask : rdc

	// ********
	// Main sequence
	// ********
	initial begin
		req = '0;
		block_in = 1'b0;
		stg_a = 1'b0;
		stg_b = 1'b0;
		stg_c = 1'b0;
		stamp = '{16'h07e8, 8'h05, 8'h11, 5'h0a, 6'h1e, 6'h2d, 10'h1f4};
		mismatches = 0;
		tests_run = 0;
		sys_rst_in = 1'b1;
		cyc(9);
		check("outputs in reset", {st, tr, bkp, frc}, 32'h0);
		@(posedge core_clk_in);
		sys_rst_in <= 1'b0;
		rdc("sel reset", bfs_pkg::OFF_SEL, 32'h1);
		rdc("delay reset", bfs_pkg::OFF_DELAY, 32'h32);
		rdc("count reset", bfs_pkg::OFF_SCNT, 32'h0);
		rdc("records reset", bfs_pkg::OFF_REC_CNT, 32'h0);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].v);
			rdc("row", rows[i].a, rows[i].e);
		end
		// Relay one outlasts 2 ms; relay two held as well must not matter
		@(posedge core_clk_in);
		stg_a <= 1'b1;
		cyc(2);
		check("start", st, 1'b1);
		n = 2;
		while (tr !== 1'b1 && n < 60) begin
			cyc(1);
			n++;
		end
		check("trip time", n >= 5 && n <= 12, 1'b1);
		@(posedge core_clk_in);
		stg_c <= 1'b1;
		cyc(20);
		check("backup held", {bkp, up_open}, 2'b11);
		@(posedge core_clk_in);
		stg_a <= 1'b0;
		cyc(3);
		check("backup released", {st, tr, bkp}, 3'b000);
		@(posedge core_clk_in);
		stg_c <= 1'b0;
		cyc(12);
		rdc("rec count", bfs_pkg::OFF_REC_CNT, 32'h1);
		wr(bfs_pkg::OFF_REC_IDX, 32'h0);
		rdc("rec pct", bfs_pkg::OFF_REC_PCT, 32'h64);
		rdc("rec date", bfs_pkg::OFF_REC_DAT, 32'h07e80511);
		rdc("rec time", bfs_pkg::OFF_REC_TOD, {5'h0, 5'h0a, 6'h1e, 6'h2d, 10'h1f4});
		rdc("start count", bfs_pkg::OFF_SCNT, 32'h1);
		rdc("trip count", bfs_pkg::OFF_TCNT, 32'h1);
		wr(bfs_pkg::OFF_SCNT, 32'h0);
		wr(bfs_pkg::OFF_TCNT, 32'h0);
		rdc("start cleared", bfs_pkg::OFF_SCNT, 32'h0);
		rdc("trip cleared", bfs_pkg::OFF_TCNT, 32'h0);
		// Two 5 ms episodes on another stage: together they would reach 10 ms
		wr(bfs_pkg::OFF_DELAY, 32'ha);
		repeat (2) begin
			@(posedge core_clk_in);
			stg_b <= 1'b1;
			cyc(20);
			@(posedge core_clk_in);
			stg_b <= 1'b0;
			cyc(12);
		end
		rdc("no trip", bfs_pkg::OFF_TCNT, 32'h0);
		rdc("two starts", bfs_pkg::OFF_SCNT, 32'h2);
		rd(bfs_pkg::OFF_REC_PCT, d);
		check("early pct", d >= 30 && d <= 60, 1'b1);
		// Relay two selected: relay one is ignored
		wr(bfs_pkg::OFF_SEL, 32'h2);
		@(posedge core_clk_in);
		stg_a <= 1'b1;
		cyc(10);
		check("unselected", st, 1'b0);
		@(posedge core_clk_in);
		stg_c <= 1'b1;
		cyc(2);
		check("selected two", st, 1'b1);
		@(posedge core_clk_in);
		stg_a <= 1'b0;
		stg_c <= 1'b0;
		wr(bfs_pkg::OFF_SEL, 32'h1);
		// Block holds the stage while the relay is energised
		@(posedge core_clk_in);
		block_in <= 1'b1;
		stg_a <= 1'b1;
		cyc(10);
		check("blocked", st, 1'b0);
		rdc("status blocked", bfs_pkg::OFF_STATUS, 32'h1);
		@(posedge core_clk_in);
		stg_a <= 1'b0;
		cyc(2);
		@(posedge core_clk_in);
		block_in <= 1'b0;
		// Nine episodes into eight records: oldest one is lost
		for (int k = 1; k <= 9; k++) begin
			@(posedge core_clk_in);
			stamp.day <= 8'(k);
			stg_a <= 1'b1;
			cyc(8);
			@(posedge core_clk_in);
			stg_a <= 1'b0;
			cyc(12);
		end
		rdc("rec full", bfs_pkg::OFF_REC_CNT, 32'h8);
		rdc("newest", bfs_pkg::OFF_REC_DAT, 32'h07e80509);
		wr(bfs_pkg::OFF_REC_IDX, 32'h7);
		rdc("oldest", bfs_pkg::OFF_REC_DAT, 32'h07e80502);
		// Forced start and trip, then the flag times out by itself
		wr(bfs_pkg::OFF_FORCE, 32'h1);
		wr(bfs_pkg::OFF_STATUS, 32'h2);
		cyc(1);
		check("forced start", {frc, st}, 2'b11);
		wr(bfs_pkg::OFF_STATUS, 32'h3);
		cyc(1);
		check("forced trip", tr, 1'b1);
		wr(bfs_pkg::OFF_STATUS, 32'h0);
		n = 8;
		while (frc === 1'b1 && n < 300) begin
			cyc(1);
			n++;
		end
		check("force time", n >= FMS * CPM - CPM && n <= FMS * CPM + CPM + 2, 1'b1);
		summarize();
	end
endmodule : bfs_stage_tb
